// *** logic/tcc_pkg.sv ***
package tcc_pkg;

  // ----------------------------------------------------------------
  // Register indices and field layout
  // ----------------------------------------------------------------
  localparam logic [4:0] IDX_RATE_SETTLE = 5'h00;
  localparam logic [4:0] IDX_AUX_FILTER = 5'h01;
  localparam logic [4:0] IDX_AVERAGING_SEL_SETTLE = 5'h02;
  localparam logic [4:0] IDX_CHAN_MASK = 5'h04;
  localparam logic [4:0] IDX_IRQ_STATUS = 5'h05;
  localparam logic [4:0] IDX_SOFT_RESET = 5'h1F;
  localparam logic [7:0] SOFT_RESET_KEY = 8'hDE;

  localparam int RATE_MSB = 7;
  localparam int RATE_LSB = 4;
  localparam int SETTLE_MSB = 3;
  localparam int AUX_MSB = 7;
  localparam int AUX_LSB = 6;
  localparam int PEN_GATE_BIT = 5;
  localparam int SCREEN_BIT = 4;
  localparam int PULL_MSB = 3;
  localparam int PULL_LSB = 2;
  localparam int AVG_MSB = 1;
  localparam int MASK_LSB = 3;
  localparam int STAT_SEQ_BIT = 7;
  localparam int STAT_TOUCH_BIT = 6;
  localparam int STAT_RESET_BIT = 5;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [7:0] RST_RATE_SETTLE = 8'h00;
  localparam logic [7:0] RST_AUX_FILTER = 8'h20;
  localparam logic [3:0] RST_AVERAGING_SEL_SETTLE = 4'h0;
  localparam logic [4:0] RST_CHAN_MASK = 5'h18;

  // Auxiliary pin trigger codes
  localparam logic [1:0] AUX_ANALOG = 2'h0;

  // ----------------------------------------------------------------
  // Timing: settle times in ns, rates in coordinates per second
  // ----------------------------------------------------------------
  localparam int unsigned CLK_HZ = 25000000;
  localparam int unsigned CLK_PERIOD_NS = 40;
  localparam int unsigned SETTLE_NS [16] = '{500, 1100, 2200, 4400,
    8900, 17800, 35500, 71000, 140000, 280000, 570000, 1140000,
    2270000, 4550000, 9090000, 18190000};
  // Entry 0 is manual mode; its value only keeps the divide legal
  localparam int unsigned RATE_CPS [16] = '{10, 10, 20, 40, 60, 80,
    100, 200, 300, 400, 500, 1000, 2000, 3000, 4000, 5000};
  localparam int CNT_W = 22;

  // ----------------------------------------------------------------
  // Carriers
  // ----------------------------------------------------------------
  typedef struct packed {
    logic write;
    logic [4:0] index;
    logic [7:0] wdata;
  } tcc_acc_type;

  typedef enum logic [0:0] {
    AUX_IDLE = 1'b0,
    AUX_SETTLE = 1'b1
  } tcc_aux_state_type;

endpackage

// *** logic/tcc_config_regs.sv ***
module tcc_config_regs #(
  parameter int unsigned SETTLE_NS [16] = tcc_pkg::SETTLE_NS,
  parameter int unsigned RATE_CPS [16] = tcc_pkg::RATE_CPS
) (
  input wire logic clk_i,
  input wire logic sys_rst_i,
  input wire logic link_clk_i,
  input wire logic acc_valid_i,
  input wire logic acc_write_i,
  input wire logic [4:0] register_index_i,
  input wire logic [7:0] acc_wdata_i,
  output logic acc_busy_o,
  output logic acc_done_o,
  output logic [7:0] acc_rdata_o,
  input wire logic aux_pin_i,
  input wire logic conv_done_i,
  input wire logic pen_detected_i,
  input wire logic touch_event_i,
  input wire logic chan_read_i,
  output logic conv_irq_o,
  output logic data_invalid_o,
  output logic acq_start_o,
  output logic manual_mode_o,
  output logic [3:0] rate_sel_o,
  output logic [3:0] initial_settle_time_o,
  output logic [1:0] aux_pin_trigger_sel_o,
  output logic pen_gated_interrupt_o,
  output logic screen_5wire_o,
  output logic [1:0] pen_pull_resistor_sel_o,
  output logic [1:0] averaging_sel_o,
  output logic [3:0] inter_sample_settle_time_o,
  output logic [4:0] channel_select_mask_o,
  output logic soft_reset_o
);

  // ----------------------------------------------------------------
  // Link domain: capture an access and hand it over by toggle
  // ----------------------------------------------------------------
  logic [1:0] link_rst_sync;
  logic req_tgl, next_req_tgl;
  tcc_pkg::tcc_acc_type hold;
  tcc_pkg::tcc_acc_type next_hold;
  logic ack_s1, ack_s2, ack_s3;
  logic link_done;
  logic [7:0] link_rdata, next_link_rdata;
  logic ack_tgl;
  logic [7:0] sys_rdata;

  // Held access stays frozen while busy, so its bits cross safely
  always_comb
  begin
    next_req_tgl = req_tgl;
    next_hold = hold;
    next_link_rdata = link_rdata;
    if (acc_valid_i && !acc_busy_o)
    begin
      next_req_tgl = ~req_tgl;
      next_hold = '{acc_write_i, register_index_i, acc_wdata_i};
    end
    if (ack_s2 != ack_s3)
      next_link_rdata = sys_rdata;
  end

  // Reset is brought in through two stages before the link uses it
  always_ff @(posedge link_clk_i)
  begin
    link_rst_sync <= {link_rst_sync[0], sys_rst_i};
    ack_s1 <= ack_tgl;
    ack_s2 <= ack_s1;
    if (link_rst_sync[1])
    begin
      req_tgl <= 1'b0;
      hold <= '0;
      ack_s3 <= 1'b0;
      link_done <= 1'b0;
      link_rdata <= 8'h00;
    end
    else
    begin
      req_tgl <= next_req_tgl;
      hold <= next_hold;
      ack_s3 <= ack_s2;
      link_done <= ack_s2 != ack_s3;
      link_rdata <= next_link_rdata;
    end
  end

  // A request during a pending access is dropped, not queued
  assign acc_busy_o = req_tgl ^ ack_s2;
  assign acc_done_o = link_done;
  assign acc_rdata_o = link_rdata;

  // ----------------------------------------------------------------
  // System domain: register file
  // ----------------------------------------------------------------
  logic req_s1, req_s2, req_s3;
  logic soft_rst;
  logic rst;
  logic access;
  logic [7:0] rate_settle;
  logic [7:0] aux_filter;
  logic [3:0] averaging_sel_settle;
  logic [4:0] chan_mask;
  logic seq_done_flag, touch_seen_flag, reset_occurred_flag;
  logic [7:0] status;
  logic next_ack_tgl;
  logic [7:0] next_sys_rdata;
  logic [7:0] next_rate_settle;
  logic [7:0] next_aux_filter;
  logic [3:0] next_averaging_sel_settle;
  logic [4:0] next_chan_mask;
  logic next_seq_done;
  logic next_touch_seen;
  logic next_soft_rst;
  logic conv_fire;

  assign rst = sys_rst_i | soft_rst;
  assign access = req_s2 ^ req_s3;
  assign status = {seq_done_flag, touch_seen_flag, reset_occurred_flag,
    5'h00};
  // Interrupt gating on pen presence
  assign conv_fire = conv_done_i &
    (~aux_filter[tcc_pkg::PEN_GATE_BIT] | pen_detected_i);

  // Decode, read mux and flag updates; events win over clears
  always_comb
  begin
    next_ack_tgl = ack_tgl;
    next_sys_rdata = sys_rdata;
    next_rate_settle = rate_settle;
    next_aux_filter = aux_filter;
    next_averaging_sel_settle = averaging_sel_settle;
    next_chan_mask = chan_mask;
    next_seq_done = seq_done_flag & ~chan_read_i;
    next_touch_seen = touch_seen_flag;
    next_soft_rst = 1'b0;
    if (access)
    begin
      next_ack_tgl = ~ack_tgl;
      next_sys_rdata = 8'h00;
      if (hold.write)
      begin
        case (hold.index)
          tcc_pkg::IDX_RATE_SETTLE: next_rate_settle = hold.wdata;
          tcc_pkg::IDX_AUX_FILTER: next_aux_filter = hold.wdata;
          tcc_pkg::IDX_AVERAGING_SEL_SETTLE:
            next_averaging_sel_settle = hold.wdata[3:0];
          tcc_pkg::IDX_CHAN_MASK:
            next_chan_mask = hold.wdata[7:tcc_pkg::MASK_LSB];
          tcc_pkg::IDX_SOFT_RESET:
            next_soft_rst = hold.wdata == tcc_pkg::SOFT_RESET_KEY;
          default: ;
        endcase
      end
      else
      begin
        case (hold.index)
          tcc_pkg::IDX_RATE_SETTLE: next_sys_rdata = rate_settle;
          tcc_pkg::IDX_AUX_FILTER: next_sys_rdata = aux_filter;
          tcc_pkg::IDX_AVERAGING_SEL_SETTLE: next_sys_rdata = {4'h0, averaging_sel_settle};
          tcc_pkg::IDX_CHAN_MASK: next_sys_rdata = {chan_mask, 3'h0};
          tcc_pkg::IDX_IRQ_STATUS:
          begin
            next_sys_rdata = status;
            next_touch_seen = 1'b0;
          end
          default: next_sys_rdata = 8'h00;
        endcase
      end
    end
    if (conv_done_i)
      next_seq_done = 1'b1;
    if (touch_event_i)
      next_touch_seen = 1'b1;
  end

  // Handshake flops see only the pin reset, so a soft reset cannot
  // tear the toggle pair apart and replay the held request
  always_ff @(posedge clk_i)
  begin
    req_s1 <= req_tgl;
    req_s2 <= req_s1;
    req_s3 <= req_s2;
    ack_tgl <= sys_rst_i ? 1'b0 : next_ack_tgl;
    if (rst)
    begin
      sys_rdata <= 8'h00;
      rate_settle <= tcc_pkg::RST_RATE_SETTLE;
      aux_filter <= tcc_pkg::RST_AUX_FILTER;
      averaging_sel_settle <= tcc_pkg::RST_AVERAGING_SEL_SETTLE;
      chan_mask <= tcc_pkg::RST_CHAN_MASK;
      seq_done_flag <= 1'b0;
      touch_seen_flag <= 1'b0;
      reset_occurred_flag <= 1'b1;
      soft_rst <= 1'b0;
    end
    else
    begin
      sys_rdata <= next_sys_rdata;
      rate_settle <= next_rate_settle;
      aux_filter <= next_aux_filter;
      averaging_sel_settle <= next_averaging_sel_settle;
      chan_mask <= next_chan_mask;
      seq_done_flag <= next_seq_done;
      touch_seen_flag <= next_touch_seen;
      reset_occurred_flag <= 1'b1;
      soft_rst <= next_soft_rst;
    end
  end

  // ----------------------------------------------------------------
  // Acquisition timing: rate timer and aux trigger settle
  // ----------------------------------------------------------------
  logic [2:0] aux_sync;
  logic aux_edge;
  logic [3:0] rate;
  logic [1:0] aux_sel;
  tcc_pkg::tcc_aux_state_type aux_state;
  tcc_pkg::tcc_aux_state_type next_aux_state;
  logic [tcc_pkg::CNT_W-1:0] settle_cnt, next_settle_cnt;
  logic [tcc_pkg::CNT_W-1:0] rate_cnt, next_rate_cnt;
  logic next_acq, acq;
  logic [tcc_pkg::CNT_W-1:0] settle_cyc [16];
  logic [tcc_pkg::CNT_W-1:0] rate_cyc [16];

  assign rate = rate_settle[tcc_pkg::RATE_MSB:tcc_pkg::RATE_LSB];
  assign aux_sel = aux_filter[tcc_pkg::AUX_MSB:tcc_pkg::AUX_LSB];

  // Least settle rounds up, rate period rounds down to keep the rate
  for (genvar g = 0; g < 16; g++)
  begin : g_tab
    assign settle_cyc[g] = tcc_pkg::CNT_W'((SETTLE_NS[g] +
      tcc_pkg::CLK_PERIOD_NS - 1) / tcc_pkg::CLK_PERIOD_NS);
    assign rate_cyc[g] =
      tcc_pkg::CNT_W'(tcc_pkg::CLK_HZ / RATE_CPS[g]);
  end

  // Only the second and third stages feed the edge detector
  assign aux_edge = (aux_sel[0] & aux_sync[1] & ~aux_sync[2]) |
    (aux_sel[1] & ~aux_sync[1] & aux_sync[2]);

  // Timer runs only in automatic mode; aux path only in manual 4-wire
  always_comb
  begin
    next_aux_state = aux_state;
    next_settle_cnt = settle_cnt;
    next_rate_cnt = rate_cnt;
    next_acq = 1'b0;
    if (rate == 4'h0)
      next_rate_cnt = '0;
    else if (rate_cnt >= rate_cyc[rate] - 1'b1)
    begin
      next_rate_cnt = '0;
      next_acq = 1'b1;
    end
    else
      next_rate_cnt = rate_cnt + 1'b1;
    case (aux_state)
      tcc_pkg::AUX_IDLE:
        if (aux_edge && rate == 4'h0 &&
          !aux_filter[tcc_pkg::SCREEN_BIT])
        begin
          next_aux_state = tcc_pkg::AUX_SETTLE;
          next_settle_cnt = settle_cyc[rate_settle[3:0]];
        end
      tcc_pkg::AUX_SETTLE:
        if (settle_cnt <= 1)
        begin
          next_aux_state = tcc_pkg::AUX_IDLE;
          next_acq = 1'b1;
        end
        else
          next_settle_cnt = settle_cnt - 1'b1;
      default: next_aux_state = tcc_pkg::AUX_IDLE;
    endcase
  end

  // Acquisition sequencer registers
  always_ff @(posedge clk_i)
  begin
    aux_sync <= {aux_sync[1:0], aux_pin_i};
    if (rst)
    begin
      aux_state <= tcc_pkg::AUX_IDLE;
      settle_cnt <= '0;
      rate_cnt <= '0;
      acq <= 1'b0;
      conv_irq_o <= 1'b0;
      data_invalid_o <= 1'b0;
    end
    else
    begin
      aux_state <= next_aux_state;
      settle_cnt <= next_settle_cnt;
      rate_cnt <= next_rate_cnt;
      acq <= next_acq;
      conv_irq_o <= conv_fire;
      data_invalid_o <= conv_done_i & ~pen_detected_i;
    end
  end

  // ----------------------------------------------------------------
  // Decoded control fields
  // ----------------------------------------------------------------
  assign acq_start_o = acq;
  assign manual_mode_o = rate == 4'h0;
  assign rate_sel_o = rate;
  assign initial_settle_time_o = rate_settle[tcc_pkg::SETTLE_MSB:0];
  assign aux_pin_trigger_sel_o = aux_sel;
  assign pen_gated_interrupt_o = aux_filter[tcc_pkg::PEN_GATE_BIT];
  assign screen_5wire_o = aux_filter[tcc_pkg::SCREEN_BIT];
  assign pen_pull_resistor_sel_o =
    aux_filter[tcc_pkg::PULL_MSB:tcc_pkg::PULL_LSB];
  assign averaging_sel_o = aux_filter[tcc_pkg::AVG_MSB:0];
  assign inter_sample_settle_time_o = averaging_sel_settle;
  assign channel_select_mask_o = chan_mask;
  assign soft_reset_o = soft_rst;

endmodule

// *** tb/tcc_host_model.sv ***
module tcc_host_model (
  input wire logic link_clk_i,
  input wire logic acc_busy_i,
  input wire logic acc_done_i,
  input wire logic [7:0] acc_rdata_i,
  output logic acc_valid_o,
  output logic acc_write_o,
  output logic [4:0] register_index_o,
  output logic [7:0] acc_wdata_o
);
  timeunit 1ns;
  timeprecision 1ps;

  // Idle lines carry junk, never a plausible request
  initial
  begin
    acc_valid_o = 1'b0;
    acc_write_o = 1'b0;
    register_index_o = 5'h0A;
    acc_wdata_o = 8'h55;
  end

  // One access; only issued when the last one finished, so busy is low
  task automatic acc(input logic w, input logic [4:0] idx,
    input logic [7:0] wd, output logic [7:0] rd, output logic ok);
    int n;
    logic busy_seen;
    @(negedge link_clk_i);
    acc_valid_o = 1'b1;
    acc_write_o = w;
    register_index_o = idx;
    acc_wdata_o = wd;
    // A request that meets busy is dropped, so it counts as failed
    busy_seen = acc_busy_i;
    @(negedge link_clk_i);
    // Released lines flip so a stale value cannot pass for a live one
    acc_valid_o = 1'b0;
    acc_write_o = ~w;
    register_index_o = ~idx;
    acc_wdata_o = ~wd;
    ok = 1'b0;
    rd = 8'h00;
    // Done and read data are taken mid-cycle, where they have settled
    for (n = 0; n < 12 && !ok; n++)
    begin
      @(negedge link_clk_i);
      ok = acc_done_i;
      rd = acc_rdata_i;
    end
    if (busy_seen)
      ok = 1'b0;
  endtask
endmodule

// *** tb/tcc_config_regs_assertions.sv ***
module tcc_config_regs_chk (
  input wire logic clk_i,
  input wire logic sys_rst_i,
  input wire logic conv_done_i,
  input wire logic pen_detected_i,
  input wire logic conv_irq_o,
  input wire logic data_invalid_o,
  input wire logic acq_start_o,
  input wire logic manual_mode_o,
  input wire logic [3:0] rate_sel_o,
  input wire logic [1:0] aux_pin_trigger_sel_o,
  input wire logic pen_gated_interrupt_o,
  input wire logic screen_5wire_o,
  input wire logic [4:0] channel_select_mask_o,
  input wire logic soft_reset_o
);
  default clocking @(posedge clk_i);
  endclocking
  default disable iff (sys_rst_i);

  a_irq_always: assert property (conv_done_i &&
    (!pen_gated_interrupt_o || pen_detected_i) |=> conv_irq_o)
    else $error("interrupt missing after conversion end");
  a_irq_gated_off: assert property (conv_done_i &&
    pen_gated_interrupt_o && !pen_detected_i |=> !conv_irq_o)
    else $error("interrupt raised without pen while gated");
  a_invalid_flag: assert property (conv_done_i |=>
    data_invalid_o != $past(pen_detected_i))
    else $error("invalid data flag wrong");
  a_irq_cause: assert property (conv_irq_o |->
    $past(conv_done_i))
    else $error("interrupt without conversion end");
  a_manual_mode: assert property (
    manual_mode_o == (rate_sel_o == 4'h0))
    else $error("manual mode does not follow rate field");
  a_reset_values: assert property (disable iff (1'b0)
    sys_rst_i |=> pen_gated_interrupt_o &&
    channel_select_mask_o == 5'h18 && !conv_irq_o)
    else $error("reset values wrong");
  a_soft_restore: assert property (soft_reset_o |=>
    channel_select_mask_o == 5'h18 && pen_gated_interrupt_o &&
    rate_sel_o == 4'h0 && !screen_5wire_o && !soft_reset_o)
    else $error("soft reset did not restore registers");
  // A timer start that lands as manual mode turns on is excluded
  a_aux_gating: assert property (acq_start_o && manual_mode_o &&
    $past(manual_mode_o) |-> !screen_5wire_o &&
    aux_pin_trigger_sel_o != tcc_pkg::AUX_ANALOG)
    else $error("aux start outside manual 4-wire");
endmodule

bind tcc_config_regs tcc_config_regs_chk i_chk (.clk_i, .sys_rst_i,
  .conv_done_i, .pen_detected_i, .conv_irq_o, .data_invalid_o,
  .acq_start_o, .manual_mode_o, .rate_sel_o, .aux_pin_trigger_sel_o,
  .pen_gated_interrupt_o, .screen_5wire_o, .channel_select_mask_o,
  .soft_reset_o);

// *** tb/tb_tcc_config_regs.sv ***
module tb_tcc_config_regs;
  timeunit 1ns;
  timeprecision 1ps;

  // Short settle (3 clk) and timer periods of 50 and 25 clk keep runs short
  localparam int unsigned T_SETTLE [16] = '{default: 100};
  localparam int unsigned T_RATE [16] = '{2: 1000000, default: 500000};
  localparam logic [4:0] RA [8] = '{5'h00, 5'h01, 5'h02, 5'h04, 5'h05,
    5'h03, 5'h06, 5'h1F};
  localparam logic [7:0] RV [8] = '{8'h00, 8'h20, 8'h00, 8'hC0, 8'h20,
    8'h00, 8'h00, 8'h00};
  localparam logic [7:0] WV [6] = '{8'h5A, 8'h96, 8'hF3, 8'hA8, 8'h00,
    8'hFF};
  localparam logic [7:0] BV [6] = '{8'h5A, 8'h96, 8'h03, 8'hA8, 8'h20,
    8'h00};
  logic clk_i, sys_rst_i, link_clk_i, acc_valid_i, acc_write_i;
  logic [4:0] register_index_i;
  logic [7:0] acc_wdata_i, acc_rdata_o;
  logic acc_busy_o, acc_done_o, aux_pin_i, conv_done_i, pen_detected_i;
  logic touch_event_i, chan_read_i, conv_irq_o, data_invalid_o;
  logic acq_start_o, manual_mode_o, pen_gated_interrupt_o;
  logic screen_5wire_o, soft_reset_o;
  logic [3:0] rate_sel_o, initial_settle_time_o, inter_sample_settle_time_o;
  logic [1:0] aux_pin_trigger_sel_o, pen_pull_resistor_sel_o;
  logic [1:0] averaging_sel_o;
  logic [4:0] channel_select_mask_o;
  int n_errors = 0;
  int compares = 0;

  tcc_config_regs #(.SETTLE_NS(T_SETTLE), .RATE_CPS(T_RATE)) i_dut (
    .clk_i, .sys_rst_i, .link_clk_i, .acc_valid_i, .acc_write_i,
    .register_index_i, .acc_wdata_i, .acc_busy_o, .acc_done_o,
    .acc_rdata_o, .aux_pin_i, .conv_done_i, .pen_detected_i,
    .touch_event_i, .chan_read_i, .conv_irq_o, .data_invalid_o,
    .acq_start_o, .manual_mode_o, .rate_sel_o, .initial_settle_time_o,
    .aux_pin_trigger_sel_o, .pen_gated_interrupt_o, .screen_5wire_o,
    .pen_pull_resistor_sel_o, .averaging_sel_o,
    .inter_sample_settle_time_o, .channel_select_mask_o, .soft_reset_o);

  tcc_host_model i_host (.link_clk_i, .acc_busy_i(acc_busy_o),
    .acc_done_i(acc_done_o), .acc_rdata_i(acc_rdata_o),
    .acc_valid_o(acc_valid_i), .acc_write_o(acc_write_i),
    .register_index_o(register_index_i), .acc_wdata_o(acc_wdata_i));

  // ------------------------------------------------------------
  // Clocks, the link one offset so no edges coincide
  // ------------------------------------------------------------
  initial
  begin
    clk_i = 1'b0;
    forever #20 clk_i = ~clk_i;
  end
  initial
  begin
    link_clk_i = 1'b0;
    #7;
    forever #24 link_clk_i = ~link_clk_i;
  end

  task automatic test_done();
    if (n_errors == 0 && compares > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [7:0] e, g);
    compares++;
    if (g !== e)
    begin
      n_errors++;
      $display("[ERR] %s exp %h got %h", nm, e, g);
    end
  endtask

  // A missing completion ends the run at once
  task automatic acc(input logic w, input logic [4:0] a,
    input logic [7:0] d, output logic [7:0] r);
    logic ok;
    i_host.acc(w, a, d, r, ok);
    if (ok !== 1'b1)
    begin
      n_errors++;
      test_done();
    end
  endtask

  task automatic wr(input logic [4:0] a, input logic [7:0] d);
    logic [7:0] r;
    acc(1'b1, a, d, r);
  endtask

  task automatic rdc(input logic [4:0] a, input logic [7:0] e);
    logic [7:0] r;
    acc(1'b0, a, 8'h00, r);
    chk("register", e, r);
  endtask

  // Event inputs are one clk wide; the registered answer is settled after
  task automatic pulse(ref logic s);
    @(negedge clk_i);
    s = 1'b1;
    @(negedge clk_i);
    s = 1'b0;
  endtask

  task automatic cnt(input int cyc, input logic [7:0] e);
    int n;
    n = 0;
    repeat (cyc)
    begin
      @(negedge clk_i);
      n += int'(acq_start_o === 1'b1);
    end
    chk("acq_starts", e, 8'(n));
  endtask

  // ------------------------------------------------------------
  // Main sequence
  // ------------------------------------------------------------
  initial
  begin
    sys_rst_i = 1'b1;
    aux_pin_i = 1'b0;
    conv_done_i = 1'b0;
    pen_detected_i = 1'b0;
    touch_event_i = 1'b0;
    chan_read_i = 1'b0;
    repeat (4) @(negedge clk_i);
    sys_rst_i = 1'b0;
    repeat (4) @(posedge link_clk_i);
    for (int i = 0; i < 8; i++)
      rdc(RA[i], RV[i]);
    for (int i = 0; i < 6; i++)
      wr(RA[i], WV[i]);
    for (int i = 0; i < 6; i++)
      rdc(RA[i], BV[i]);
    chk("rate", 8'h05, {4'h0, rate_sel_o});
    chk("manual", 8'h00, {7'h0, manual_mode_o});
    chk("settle", 8'h0A, {4'h0, initial_settle_time_o});
    chk("aux_sel", 8'h02, {6'h0, aux_pin_trigger_sel_o});
    chk("gate", 8'h00, {7'h0, pen_gated_interrupt_o});
    chk("screen", 8'h01, {7'h0, screen_5wire_o});
    chk("pull", 8'h01, {6'h0, pen_pull_resistor_sel_o});
    chk("avg", 8'h02, {6'h0, averaging_sel_o});
    chk("inter", 8'h03, {4'h0, inter_sample_settle_time_o});
    chk("mask", 8'h15, {3'h0, channel_select_mask_o});
    // Interrupt gating over both gate settings and pen states
    for (int i = 0; i < 4; i++)
    begin
      wr(5'h01, {2'h0, i[1], 5'h00});
      @(negedge clk_i) pen_detected_i = i[0];
      pulse(conv_done_i);
      chk("irq", {7'h0, !i[1] || i[0]}, {7'h0, conv_irq_o});
      chk("invalid", {7'h0, !i[0]}, {7'h0, data_invalid_o});
    end
    rdc(5'h05, 8'hA0);
    pulse(chan_read_i);
    rdc(5'h05, 8'h20);
    pulse(touch_event_i);
    rdc(5'h05, 8'h60);
    rdc(5'h05, 8'h20);
    // Timer periods 50 and 25 clk give 4 and 8 starts in 200 clk
    wr(5'h00, 8'h10);
    cnt(200, 8'h04);
    wr(5'h00, 8'h20);
    cnt(200, 8'h08);
    wr(5'h00, 8'h00);
    cnt(200, 8'h00);
    // Every trigger code, rising then falling edge
    for (int c = 0; c < 4; c++)
    begin
      wr(5'h01, {c[1:0], 6'h00});
      @(negedge clk_i) aux_pin_i = 1'b1;
      cnt(20, {7'h0, c[0]});
      aux_pin_i = 1'b0;
      cnt(20, {7'h0, c[1]});
    end
    wr(5'h01, 8'hD0);
    @(negedge clk_i) aux_pin_i = 1'b1;
    cnt(20, 8'h00);
    aux_pin_i = 1'b0;
    cnt(20, 8'h00);
    wr(5'h00, 8'h5A);
    wr(5'h1F, 8'h12);
    rdc(5'h00, 8'h5A);
    wr(5'h1F, 8'hDE);
    rdc(5'h00, 8'h00);
    rdc(5'h01, 8'h20);
    rdc(5'h04, 8'hC0);
    test_done();
  end
endmodule
